// [core/rxq_device.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rxq_params.svh"
// Behaviour
// - queue holds 255 entries of 24 bits
// - trigger when occupancy exceeds the threshold
// - threshold at most 254 mono, 253 stereo
// - freeze while streaming blocks writes, holds pointer
// - freeze pops advance until queue empty
// - leave freeze by toggling converter enable
// - clear resets read and write pointers
// - no pop or peek while clear set
// - status shows occupancy and both pointers
// - write pointer advances per stored sample
// - read pointer advances on every pop from a non-empty queue
// - peek returns oldest entry, pointer unmoved
// - dma request enabled, high above threshold
// - dma reads one fixed pop address
// - drain threshold plus one words per trigger
// - stereo alternates left then right; mono one channel
// - right aligned, zero or sign fill
// - separate overflow and underflow events
// - full queue flags overflow, drops new samples
// - pop from empty queue flags underflow

module rxq_device
    import rxq_pkg::*;
#(
    parameter int DEPTH = `RXQ_DEPTH,
    parameter int PTR_W = `RXQ_PTR_W
)
(
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST,
    // samples from the internal receive buffer
    input  wire logic                  SMP_VALID,
    input  wire logic [`RXQ_SMP_W-1:0] SMP_LEFT,
    input  wire logic [`RXQ_SMP_W-1:0] SMP_RIGHT,
    // reading party
    rxq_link_if.dev                    LINK
);

    // ====================
    // constants
    localparam logic [PTR_W-1:0] LAST_IDX  = PTR_W'(DEPTH - 1);
    localparam logic [PTR_W:0]   DEPTH_VAL = (PTR_W + 1)'(DEPTH);
    localparam int               FILL24    = `RXQ_WORD_W - `RXQ_SMP_W;
    localparam int               FILL20    = `RXQ_WORD_W - `RXQ_NARROW_W;

    // ====================
    // state
    logic [`RXQ_SMP_W-1:0]  mem_ff [0:DEPTH-1];
    logic [PTR_W-1:0]       wr_ptr_ff;
    logic [PTR_W-1:0]       rd_ptr_ff;
    logic [PTR_W-1:0]       count_ff;
    logic                   pend_ff;
    logic [`RXQ_SMP_W-1:0]  pend_data_ff;
    logic [`RXQ_WORD_W-1:0] rd_data_ff;
    logic                   rd_valid_ff;
    logic                   underflow_ff;
    logic                   overflow_ff;
    logic                   trigger_ff;
    logic                   not_empty_ff;
    logic                   dma_req_ff;

    // ====================
    // combinational
    logic                   flush;
    logic                   accept;
    logic [PTR_W:0]         free_slots;
    logic                   wr_en;
    logic [`RXQ_SMP_W-1:0]  wr_data;
    logic                   set_pend;
    logic                   ovf;
    logic                   pop_ok;
    logic                   pop_empty;
    logic                   above;
    logic [PTR_W-1:0]       nxt_count;

    function automatic logic [PTR_W-1:0] bump(
        input logic [PTR_W-1:0] p
    );
        bump = (p == LAST_IDX) ? '0 : p + 1'b1;
    endfunction

    // right aligned word with zero or sign fill
    function automatic logic [`RXQ_WORD_W-1:0] shape(
        input logic [`RXQ_SMP_W-1:0] s,
        input width_t                w,
        input logic                  ext
    );
        logic fill;
        if (w == WIDTH_20) begin
            fill  = ext & s[`RXQ_NARROW_W-1];
            shape = {{FILL20{fill}}, s[`RXQ_NARROW_W-1:0]};
        end else begin
            fill  = ext & s[`RXQ_SMP_W-1];
            shape = {{FILL24{fill}}, s};
        end
    endfunction

    // ====================
    // write side
    // converter disable acts as a synchronous reset of the queue
    assign flush      = !LINK.converter_enable || LINK.clear;
    assign accept     = LINK.streaming_on && !LINK.freeze && !flush;
    assign free_slots = DEPTH_VAL - {1'b0, count_ff};

    always_comb begin
        wr_en    = 1'b0;
        wr_data  = '0;
        set_pend = 1'b0;
        ovf      = 1'b0;
        if (pend_ff && accept) begin
            // second half of a stereo pair, room reserved already
            wr_en   = 1'b1;
            wr_data = pend_data_ff;
        end else if (SMP_VALID && accept) begin
            case (LINK.mode)
                MODE_MONO_L, MODE_MONO_R: begin
                    if (free_slots != '0) begin
                        wr_en   = 1'b1;
                        wr_data = LINK.mode[0] ? SMP_LEFT : SMP_RIGHT;
                    end else begin
                        ovf = 1'b1;
                    end
                end
                MODE_STEREO: begin
                    // whole pair or nothing keeps left/right order intact
                    if (free_slots > (PTR_W + 1)'(1)) begin
                        wr_en    = 1'b1;
                        wr_data  = SMP_LEFT;
                        set_pend = 1'b1;
                    end else begin
                        ovf = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // ====================
    // read side
    assign pop_ok    = LINK.pop_req && !flush && (count_ff != '0);
    assign pop_empty = LINK.pop_req && !flush && (count_ff == '0);

    always_comb begin
        if (flush) begin
            nxt_count = '0;
        end else begin
            nxt_count = count_ff + PTR_W'(wr_en) - PTR_W'(pop_ok);
        end
    end

    assign above = nxt_count > LINK.trigger_level;

    // ====================
    // pointers and occupancy
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (wr_en) begin
                wr_ptr_ff <= bump(wr_ptr_ff);
            end
            if (pop_ok) begin
                rd_ptr_ff <= bump(rd_ptr_ff);
            end
            count_ff <= nxt_count;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pend_ff      <= 1'b0;
            pend_data_ff <= '0;
        end else begin
            pend_ff <= set_pend;
            if (set_pend) begin
                pend_data_ff <= SMP_RIGHT;
            end
        end
    end

    // storage, 255 words of 24 bits
    always_ff @(posedge CORE_CLK) begin
        if (wr_en) begin
            mem_ff[wr_ptr_ff] <= wr_data;
        end
    end

    // ====================
    // register answers
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rd_data_ff   <= `RXQ_WORD_RST;
            rd_valid_ff  <= 1'b0;
            underflow_ff <= 1'b0;
        end else begin
            rd_valid_ff  <= (LINK.pop_req || LINK.peek_req) && !flush;
            underflow_ff <= pop_empty;
            if (pop_ok || (LINK.peek_req && !flush && count_ff != '0)) begin
                rd_data_ff <= shape(mem_ff[rd_ptr_ff],
                                    LINK.sample_width_select,
                                    LINK.bit_extension);
            end else begin
                rd_data_ff <= `RXQ_WORD_RST;
            end
        end
    end

    // ====================
    // events and dma request
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            overflow_ff  <= 1'b0;
            trigger_ff   <= 1'b0;
            not_empty_ff <= 1'b0;
            dma_req_ff   <= 1'b0;
        end else begin
            overflow_ff  <= ovf;
            trigger_ff   <= above;
            not_empty_ff <= nxt_count != '0;
            dma_req_ff   <= above && LINK.dma_request_enable;
        end
    end

    // ====================
    // outputs
    assign LINK.rd_data         = rd_data_ff;
    assign LINK.rd_valid        = rd_valid_ff;
    assign LINK.underflow_evt   = underflow_ff;
    assign LINK.overflow_evt    = overflow_ff;
    assign LINK.trigger_evt     = trigger_ff;
    assign LINK.not_empty       = not_empty_ff;
    assign LINK.dma_request_out = dma_req_ff;
    assign LINK.status_count    = count_ff;
    assign LINK.status_rd_ptr   = rd_ptr_ff;
    assign LINK.status_wr_ptr   = wr_ptr_ff;

endmodule

`default_nettype wire

// [common/rxq_params.svh]
`ifndef RXQ_PARAMS_SVH
`define RXQ_PARAMS_SVH

// =====================================================================
// queue geometry
`define RXQ_DEPTH            255
`define RXQ_PTR_W            8
`define RXQ_SMP_W            24
`define RXQ_NARROW_W         20
`define RXQ_WORD_W           32
`define RXQ_CNT_W            9

// =====================================================================
// threshold limits and reset values
`define RXQ_MONO_MAX_LEVEL   8'hFE
`define RXQ_STEREO_MAX_LEVEL 8'hFD
`define RXQ_LEVEL_RST        8'h00
`define RXQ_WORD_RST         32'h0000_0000

// =====================================================================
// reader pacing
`define RXQ_SETTLE_CYCLES    2'h2

`endif

// [common/rxq_pkg.sv]
package rxq_pkg;

    // recording mode: off, mono left, mono right or stereo
    typedef enum logic [1:0] {
        MODE_OFF    = 2'h0,
        MODE_MONO_L = 2'h1,
        MODE_MONO_R = 2'h2,
        MODE_STEREO = 2'h3
    } mode_t;

    typedef enum logic {
        WIDTH_24 = 1'h0,
        WIDTH_20 = 1'h1
    } width_t;

    typedef enum logic [3:0] {
        RD_IDLE   = 4'h1,
        RD_WAIT   = 4'h2,
        RD_SETTLE = 4'h4,
        RD_SPARE  = 4'h8
    } rd_state_t;

endpackage

// [common/rxq_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rxq_params.svh"

interface rxq_link_if;
    import rxq_pkg::*;

    // ====================
    // configuration written by the reading party
    logic [`RXQ_PTR_W-1:0]  trigger_level;
    logic                   freeze;
    logic                   clear;
    logic                   streaming_on;
    logic                   converter_enable;
    logic                   dma_request_enable;
    logic                   bit_extension;
    width_t                 sample_width_select;
    mode_t                  mode;

    // ====================
    // register accesses
    logic                   pop_req;
    logic                   peek_req;
    logic [`RXQ_WORD_W-1:0] rd_data;
    logic                   rd_valid;

    // ====================
    // events and status
    logic                   dma_request_out;
    logic                   trigger_evt;
    logic                   not_empty;
    logic                   overflow_evt;
    logic                   underflow_evt;
    logic [`RXQ_PTR_W-1:0]  status_count;
    logic [`RXQ_PTR_W-1:0]  status_rd_ptr;
    logic [`RXQ_PTR_W-1:0]  status_wr_ptr;

    modport dev (
        input  trigger_level, freeze, clear, streaming_on,
        input  converter_enable, dma_request_enable, bit_extension,
        input  sample_width_select, mode, pop_req, peek_req,
        output rd_data, rd_valid, dma_request_out, trigger_evt,
        output not_empty, overflow_evt, underflow_evt,
        output status_count, status_rd_ptr, status_wr_ptr
    );

    modport rdr (
        output trigger_level, freeze, clear, streaming_on,
        output converter_enable, dma_request_enable, bit_extension,
        output sample_width_select, mode, pop_req, peek_req,
        input  rd_data, rd_valid, dma_request_out, trigger_evt,
        input  not_empty, overflow_evt, underflow_evt,
        input  status_count, status_rd_ptr, status_wr_ptr
    );

endinterface

`default_nettype wire

// [core/rxq_reader.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rxq_params.svh"

module rxq_reader
    import rxq_pkg::*;
(
    // clock and reset
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST,
    // queue link
    rxq_link_if.rdr                     LINK,
    // configuration
    input  wire logic [`RXQ_PTR_W-1:0]  CFG_LEVEL,
    input  wire logic                   CFG_FREEZE,
    input  wire logic                   CFG_CLEAR,
    input  wire logic                   CFG_STREAM,
    input  wire logic                   CFG_ENABLE,
    input  wire logic                   CFG_DMA_EN,
    input  wire logic                   CFG_BIT_EXT,
    input  wire width_t                 CFG_WIDTH,
    input  wire mode_t                  CFG_MODE,
    // commands
    input  wire logic                   CMD_POP,
    input  wire logic                   CMD_PEEK,
    input  wire logic                   AUTO_DRAIN,
    // delivered words
    output logic [`RXQ_WORD_W-1:0]      WORD_DATA,
    output logic                        WORD_VALID,
    output logic                        WORD_UNDERFLOW,
    output logic                        BUSY
);

    // ====================
    // state
    rd_state_t              state_ff;
    logic [`RXQ_CNT_W-1:0]  left_ff;
    logic [1:0]             settle_ff;
    logic                   pop_ff;
    logic                   peek_ff;
    logic [`RXQ_PTR_W-1:0]  level_ff;
    logic                   freeze_ff;
    logic                   clear_ff;
    logic                   stream_ff;
    logic                   enable_ff;
    logic                   dma_en_ff;
    logic                   ext_ff;
    width_t                 width_ff;
    mode_t                  mode_ff;
    logic [`RXQ_PTR_W-1:0]  nxt_level;

    // ====================
    // configuration registers
    always_comb begin
        if (CFG_MODE == MODE_STEREO && CFG_LEVEL > `RXQ_STEREO_MAX_LEVEL) begin
            nxt_level = `RXQ_STEREO_MAX_LEVEL;
        end else if (CFG_LEVEL > `RXQ_MONO_MAX_LEVEL) begin
            nxt_level = `RXQ_MONO_MAX_LEVEL;
        end else begin
            nxt_level = CFG_LEVEL;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            level_ff  <= `RXQ_LEVEL_RST;
            freeze_ff <= 1'b0;
            clear_ff  <= 1'b0;
            stream_ff <= 1'b0;
            enable_ff <= 1'b0;
            dma_en_ff <= 1'b0;
            ext_ff    <= 1'b0;
            width_ff  <= WIDTH_24;
            mode_ff   <= MODE_OFF;
        end else begin
            level_ff  <= nxt_level;
            freeze_ff <= CFG_FREEZE;
            clear_ff  <= CFG_CLEAR;
            stream_ff <= CFG_STREAM;
            // leaving freeze drops enable for one cycle
            enable_ff <= CFG_ENABLE && !(freeze_ff && !CFG_FREEZE);
            dma_en_ff <= CFG_DMA_EN;
            ext_ff    <= CFG_BIT_EXT;
            width_ff  <= CFG_WIDTH;
            mode_ff   <= CFG_MODE;
        end
    end

    // ====================
    // drain engine: one access in flight, answer next cycle
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_ff  <= RD_IDLE;
            left_ff   <= '0;
            settle_ff <= '0;
            pop_ff    <= 1'b0;
            peek_ff   <= 1'b0;
        end else begin
            pop_ff  <= 1'b0;
            peek_ff <= 1'b0;
            case (state_ff)
                RD_IDLE: begin
                    if (!clear_ff) begin
                        if (AUTO_DRAIN && LINK.dma_request_out) begin
                            // fixed pop address, device walks the queue
                            pop_ff   <= 1'b1;
                            left_ff  <= {1'b0, level_ff} + 1'b1;
                            state_ff <= RD_WAIT;
                        end else if (CMD_POP) begin
                            pop_ff   <= 1'b1;
                            left_ff  <= `RXQ_CNT_W'(1);
                            state_ff <= RD_WAIT;
                        end else if (CMD_PEEK) begin
                            peek_ff  <= 1'b1;
                            left_ff  <= `RXQ_CNT_W'(1);
                            state_ff <= RD_WAIT;
                        end
                    end
                end
                RD_WAIT: begin
                    if (LINK.rd_valid || clear_ff || !enable_ff) begin
                        if (left_ff > `RXQ_CNT_W'(1) && !clear_ff) begin
                            pop_ff  <= 1'b1;
                            left_ff <= left_ff - 1'b1;
                        end else begin
                            left_ff   <= '0;
                            settle_ff <= `RXQ_SETTLE_CYCLES;
                            state_ff  <= RD_SETTLE;
                        end
                    end
                end
                RD_SETTLE: begin
                    // let the request flop see the drained occupancy
                    if (settle_ff == 2'h0) begin
                        state_ff <= RD_IDLE;
                    end else begin
                        settle_ff <= settle_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= RD_IDLE;
                end
            endcase
        end
    end

    // ====================
    // delivered words
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            WORD_DATA      <= `RXQ_WORD_RST;
            WORD_VALID     <= 1'b0;
            WORD_UNDERFLOW <= 1'b0;
            BUSY           <= 1'b0;
        end else begin
            WORD_VALID     <= LINK.rd_valid;
            WORD_UNDERFLOW <= LINK.underflow_evt;
            BUSY           <= state_ff != RD_IDLE;
            if (LINK.rd_valid) begin
                WORD_DATA <= LINK.rd_data;
            end
        end
    end

    assign LINK.trigger_level       = level_ff;
    assign LINK.freeze              = freeze_ff;
    assign LINK.clear               = clear_ff;
    assign LINK.streaming_on        = stream_ff;
    assign LINK.converter_enable    = enable_ff;
    assign LINK.dma_request_enable  = dma_en_ff;
    assign LINK.bit_extension       = ext_ff;
    assign LINK.sample_width_select = width_ff;
    assign LINK.mode                = mode_ff;
    assign LINK.pop_req             = pop_ff;
    assign LINK.peek_req            = peek_ff;

endmodule

`default_nettype wire

// [sim/rxq_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module rxq_checker
    import rxq_pkg::*;
(
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // reader side
    input wire logic [7:0]  trigger_level,
    input wire logic        freeze,
    input wire logic        clear,
    input wire logic        streaming_on,
    input wire logic        converter_enable,
    input wire logic        dma_request_enable,
    input wire logic        bit_extension,
    input wire width_t      sample_width_select,
    input wire logic        pop_req,
    input wire logic        peek_req,
    // device side
    input wire logic [31:0] rd_data,
    input wire logic        rd_valid,
    input wire logic        dma_request_out,
    input wire logic        trigger_evt,
    input wire logic        not_empty,
    input wire logic        underflow_evt,
    input wire logic [7:0]  status_count,
    input wire logic [7:0]  status_rd_ptr,
    input wire logic [7:0]  status_wr_ptr
);
    // ====================
    // queue properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    trig_level_a: assert property (
        trigger_level == $past(trigger_level) |->
        trigger_evt == (status_count > trigger_level)) else $error("bad trig");
    dma_gate_a: assert property (
        dma_request_enable == $past(dma_request_enable) |->
        dma_request_out == (trigger_evt && dma_request_enable))
        else $error("bad dma");
    nempty_flag_a: assert property (
        not_empty == (status_count != 8'h00)) else $error("bad not_empty");
    answer_time_a: assert property (
        (pop_req || peek_req) && !clear && converter_enable |=> rd_valid)
        else $error("no answer");
    no_stray_a: assert property (
        rd_valid |-> $past(pop_req || peek_req)) else $error("stray answer");
    pop_step_a: assert property (
        pop_req && !clear && converter_enable && status_count != 8'h00 &&
        status_rd_ptr != 8'hFE |=>
        status_rd_ptr == $past(status_rd_ptr) + 8'h01) else $error("no step");
    empty_pop_a: assert property (
        pop_req && !clear && converter_enable && status_count == 8'h00 |=>
        underflow_evt && rd_data == 32'h0 && $stable(status_rd_ptr))
        else $error("bad empty pop");
    freeze_hold_a: assert property (
        freeze && streaming_on && !clear && converter_enable |=>
        $stable(status_wr_ptr)) else $error("write in freeze");
    clear_empty_a: assert property (
        clear |=> status_count == 8'h00 && status_wr_ptr == 8'h00 &&
        status_rd_ptr == 8'h00) else $error("clear failed");
    fill24_a: assert property (
        rd_valid && sample_width_select == WIDTH_24 |-> rd_data[31:24] ==
        (bit_extension ? {8{rd_data[23]}} : 8'h00)) else $error("bad fill");
    fill20_a: assert property (
        rd_valid && sample_width_select == WIDTH_20 |-> rd_data[31:20] ==
        (bit_extension ? {12{rd_data[19]}} : 12'h000)) else $error("bad fill");
endmodule
`default_nettype wire

// [sim/pcm_capture_rx_fifo_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pcm_capture_rx_fifo_tb_top;
    import rxq_pkg::*;
    // ====================
    // stimulus and observation
    logic        CORE_CLK, RST, sv, frz, clr, strm, en, dma, ext;
    logic        auto, pop, peek, wv, wu, busy, uf, ovf;
    logic [7:0]  lvl, p;
    logic [23:0] sl, sr;
    logic [31:0] wd, d;
    width_t      wid;
    mode_t       md;
    int          err_total, check_count;
    rxq_link_if link ();
    rxq_device rxq_device_inst (.CORE_CLK(CORE_CLK), .RST(RST),
        .SMP_VALID(sv), .SMP_LEFT(sl), .SMP_RIGHT(sr), .LINK(link));
    rxq_reader rxq_reader_inst (.CORE_CLK(CORE_CLK), .RST(RST), .LINK(link),
        .CFG_LEVEL(lvl), .CFG_FREEZE(frz), .CFG_CLEAR(clr), .CFG_STREAM(strm),
        .CFG_ENABLE(en), .CFG_DMA_EN(dma), .CFG_BIT_EXT(ext), .CFG_WIDTH(wid),
        .CFG_MODE(md), .CMD_POP(pop), .CMD_PEEK(peek), .AUTO_DRAIN(auto),
        .WORD_DATA(wd), .WORD_VALID(wv), .WORD_UNDERFLOW(wu), .BUSY(busy));
    rxq_checker rxq_checker_inst (.CORE_CLK(CORE_CLK), .RST(RST),
        .trigger_level(link.trigger_level), .freeze(link.freeze),
        .clear(link.clear), .streaming_on(link.streaming_on),
        .converter_enable(link.converter_enable),
        .dma_request_enable(link.dma_request_enable),
        .bit_extension(link.bit_extension),
        .sample_width_select(link.sample_width_select),
        .pop_req(link.pop_req), .peek_req(link.peek_req),
        .rd_data(link.rd_data), .rd_valid(link.rd_valid),
        .dma_request_out(link.dma_request_out),
        .trigger_evt(link.trigger_evt), .not_empty(link.not_empty),
        .underflow_evt(link.underflow_evt),
        .status_count(link.status_count),
        .status_rd_ptr(link.status_rd_ptr),
        .status_wr_ptr(link.status_wr_ptr));
    initial begin
        CORE_CLK = 1'b0;
        forever #2 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        if (link.overflow_evt === 1'b1) ovf <= 1'b1;
        if (wu === 1'b1) uf <= 1'b1;
    end
    // ====================
    // shared tasks
    task automatic chk(input string n, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge CORE_CLK);
    endtask
    task automatic push(input logic [23:0] l, r);
        wt(1);
        sv = 1'b1;
        sl = l;
        sr = r;
        wt(1);
        sv = 1'b0;
        wt(1);
    endtask
    task automatic rd(input logic is_pop);
        int k;
        wt(1);
        uf = 1'b0;
        pop = is_pop;
        peek = !is_pop;
        wt(1);
        pop = 1'b0;
        peek = 1'b0;
        for (k = 0; k < 20 && wv !== 1'b1; k++) wt(1);
        chk("answer", wv, 1'b1);
        d = wd;
        for (k = 0; k < 20 && busy === 1'b1; k++) wt(1);
    endtask
    task automatic reopen(input mode_t m);
        wt(1);
        md = m;
        frz = 1'b0;
        en = 1'b0;
        wt(4);
        en = 1'b1;
        wt(4);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // scenarios
    task automatic t_format;
        reopen(MODE_MONO_L);
        for (int i = 0; i < 4; i++) begin
            wid = width_t'(i[1]);
            ext = i[0];
            wt(3);
            push(24'h8A5F3C, 24'h000001);
            rd(1'b1);
            chk("format", d, wid == WIDTH_24 ? {{8{ext}}, 24'h8A5F3C} :
                {{12{ext}}, 20'hA5F3C});
        end
        wid = WIDTH_24;
        ext = 1'b0;
        md = MODE_MONO_R;
        wt(3);
        push(24'h000011, 24'h000022);
        rd(1'b1);
        chk("mono right", d, 32'h22);
        $display("format test done");
    endtask
    task automatic t_stereo;
        reopen(MODE_STEREO);
        push(24'h000A01, 24'h000B01);
        push(24'h000A02, 24'h000B02);
        chk("count", link.status_count, 8'h04);
        chk("wr ptr", link.status_wr_ptr, 8'h04);
        rd(1'b0);
        chk("peek", d, 32'hA01);
        chk("peek count", link.status_count, 8'h04);
        for (int i = 0; i < 4; i++) begin
            rd(1'b1);
            chk("stereo", d, {20'h0, i[0] ? 4'hB : 4'hA,
                8'(i / 2 + 1)});
        end
        chk("rd ptr", link.status_rd_ptr, 8'h04);
        p = link.status_rd_ptr;
        rd(1'b1);
        chk("underflow data", d, 32'h0);
        chk("underflow flag", uf, 1'b1);
        chk("rd ptr kept", link.status_rd_ptr, p);
        $display("stereo test done");
    endtask
    task automatic t_freeze;
        reopen(MODE_MONO_L);
        push(24'h000001, 24'h0);
        push(24'h000002, 24'h0);
        frz = 1'b1;
        wt(3);
        p = link.status_wr_ptr;
        push(24'h000003, 24'h0);
        chk("freeze wr ptr", link.status_wr_ptr, p);
        chk("freeze count", link.status_count, 8'h02);
        for (int i = 0; i < 3; i++) begin
            rd(1'b1);
            chk("freeze pop", d, i < 2 ? 32'(i + 1) : 32'h0);
        end
        chk("freeze rd ptr", link.status_rd_ptr, 8'h02);
        $display("freeze test done");
    endtask
    task automatic t_trigger;
        int k;
        reopen(MODE_MONO_L);
        lvl = 8'h03;
        wt(3);
        for (int i = 0; i < 6; i++) begin
            push(24'(i), 24'h0);
            if (i == 2) chk("no trigger", link.trigger_evt, 1'b0);
        end
        chk("trigger", link.trigger_evt, 1'b1);
        chk("dma off", link.dma_request_out, 1'b0);
        dma = 1'b1;
        wt(3);
        chk("dma on", link.dma_request_out, 1'b1);
        auto = 1'b1;
        for (k = 0; k < 100 && link.status_count !== 8'h02; k++) wt(1);
        wt(2);
        for (k = 0; k < 40 && busy === 1'b1; k++) wt(1);
        auto = 1'b0;
        chk("drain", link.status_count, 8'h02);
        chk("drain ptr", link.status_rd_ptr, 8'h04);
        $display("trigger test done");
    endtask
    task automatic t_overflow;
        reopen(MODE_MONO_L);
        dma = 1'b0;
        lvl = 8'hFE;
        for (int i = 0; i < 255; i++) push(24'(i + 1), 24'h0);
        chk("full", link.status_count, 8'hFF);
        ovf = 1'b0;
        push(24'h00ABCD, 24'h0);
        wt(2);
        chk("overflow", ovf, 1'b1);
        chk("full kept", link.status_count, 8'hFF);
        rd(1'b1);
        chk("oldest", d, 32'h1);
        clr = 1'b1;
        wt(3);
        chk("clear", {link.status_count, link.status_wr_ptr,
            link.status_rd_ptr}, 32'h0);
        clr = 1'b0;
        $display("overflow test done");
    endtask
    initial begin
        {RST, strm, en} = 3'h7;
        {sv, frz, clr, dma, ext, auto, pop, peek, uf, ovf} = 10'h000;
        {lvl, sl, sr} = 56'h0;
        wid = WIDTH_24;
        md = MODE_OFF;
        err_total = 0;
        check_count = 0;
        wt(10);
        RST = 1'b0;
        wt(2);
        t_format;
        t_stereo;
        t_freeze;
        t_trigger;
        t_overflow;
        complete_run;
    end
    initial begin
        #200000;
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire
